/* design/oba_matrix.sv */
// On-chip bus matrix arbiter: CPU fetch and operand buses, CPU main bus,
// second main bus for the transfer engines, RAM, ROM and peripheral buses.
// Assumes masters hold a request until its accept pulse and that each target
// bus pulses its done line once when the granted transfer ends.
`timescale 1ns/100ps
`include "oba_params.svh"
module oba_matrix
	import oba_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Priority configuration load.
	input wire logic cfg_load,
	input wire logic [1:0] ram_bus_prio_sel,
	input wire logic [1:0] rom_bus_prio_sel,
	input wire logic [1:0] periph1_prio_sel,
	input wire logic [1:0] periph2_prio_sel,
	input wire logic [1:0] periph6_prio_sel,
	output logic [11:0] bus_priority_config,
	// CPU instruction bus.
	input wire logic if_req,
	input wire logic [2:0] if_tgt,
	output logic if_gnt,
	// CPU operand bus.
	input wire logic op_req,
	input wire logic [2:0] op_tgt,
	input wire logic op_wr,
	output logic op_gnt,
	output logic op_rom_wr_reject,
	// Second main bus, driven by the engine that holds an activation.
	input wire logic m2_req,
	input wire logic [2:0] m2_tgt,
	input wire logic m2_wr,
	output logic m2_gnt,
	// Transfer engine activation.
	input wire logic [3:0] dma_act_req,
	input wire logic dtc_act_req,
	input wire logic eng_release,
	output logic [4:0] eng_accept,
	output logic [4:0] eng_owner,
	// Bus locks.
	input wire logic atomic_atomic_exchange_instruction_active,
	input wire logic dtc_desc_active,
	// Target buses.
	input wire logic [4:0] tgt_done,
	output logic [4:0] tgt_own_m2,
	output logic [4:0] tgt_own_op,
	output logic [4:0] tgt_own_if
);

	oba_mx_st_t s;
	oba_mx_st_t next_s;
	logic [1:0] prio_sel [`OBA_NUM_TGT];
	logic [2:0] cell_acc [`OBA_NUM_TGT];
	logic [2:0] cell_own [`OBA_NUM_TGT];
	logic [4:0] req_m2;
	logic [4:0] req_op;
	logic [4:0] req_if;
	logic [4:0] acc_m2;
	logic [4:0] acc_op;
	logic [4:0] acc_if;
	logic m2_live;
	logic op_live;
	logic if_live;
	logic op_per;
	logic op_tgt_per;
	logic m2_tgt_per;
	logic [4:0] tgt_free; // Targets with no owner; read by the checks only.

	// ************************************************************
	// Request qualification
	// ************************************************************

	// Only the engine that accepted an activation may use the second main bus;
	// an atomic exchange keeps it off every target.
	assign m2_live = m2_req && (s.eng != ENG_IDLE) && !atomic_atomic_exchange_instruction_active;
	// Descriptor fetch and write-back shut the CPU out.
	assign op_live = op_req && !dtc_desc_active;
	assign if_live = if_req && !dtc_desc_active;
	assign op_tgt_per = (op_tgt >= `OBA_TGT_P1);
	assign m2_tgt_per = (m2_tgt >= `OBA_TGT_P1);
	// The CPU main bus carries one access; an operand there keeps fetch out.
	assign op_per = op_req && op_tgt_per;
	// The direct ROM path is read only; a write there is refused.
	assign op_rom_wr_reject = op_req && op_wr && (op_tgt == `OBA_TGT_ROM);

	// Mode selection of each target bus.
	assign prio_sel[`OBA_TGT_RAM] = s.prio[`OBA_PRIO_RAM +: 2];
	assign prio_sel[`OBA_TGT_ROM] = s.prio[`OBA_PRIO_ROM +: 2];
	assign prio_sel[`OBA_TGT_P1] = s.prio[`OBA_PRIO_P1 +: 2];
	assign prio_sel[`OBA_TGT_P2] = s.prio[`OBA_PRIO_P2 +: 2];
	assign prio_sel[`OBA_TGT_P6] = s.prio[`OBA_PRIO_P6 +: 2];

	// ************************************************************
	// Target bus arbiters
	// ************************************************************

	// One arbiter per target; separate targets run in parallel, so fetch,
	// operand and the second main bus can all move in the same cycle.
	for (genvar t = 0; t < `OBA_NUM_TGT; t++)
	begin : g_tgt
		localparam logic [2:0] TI = 3'(t);
		localparam bit PER = (TI >= `OBA_TGT_P1);
		logic cpu_wb_ok;
		logic m2_wb_ok;

		// A buffered write to another peripheral bus holds the same master.
		assign cpu_wb_ok = !PER || !s.cpu_pend || (s.cpu_pend_tgt == TI);
		assign m2_wb_ok = !PER || !s.m2_pend || (s.m2_pend_tgt == TI);
		assign req_m2[t] = m2_live && (m2_tgt == TI) && m2_wb_ok;
		assign req_op[t] = op_live && (op_tgt == TI) && cpu_wb_ok
			&& !((TI == `OBA_TGT_ROM) && op_wr);
		// Memory targets see the fetch directly; peripherals only via main bus 1.
		assign req_if[t] = if_live && (if_tgt == TI) && (!PER || (cpu_wb_ok && !op_per));

		oba_tgt_arb u_arb (
			.clock(clock),
			.rst_b(rst_b),
			.toggled(prio_sel[t] == `OBA_MODE_TOGGLE),
			.req_m2(req_m2[t]),
			.req_op(req_op[t]),
			.req_if(req_if[t]),
			.done(tgt_done[t]),
			.acc(cell_acc[t]),
			.own(cell_own[t])
		);

		assign acc_m2[t] = cell_acc[t][`OBA_M_M2];
		assign acc_op[t] = cell_acc[t][`OBA_M_OP];
		assign acc_if[t] = cell_acc[t][`OBA_M_IF];
		assign tgt_own_m2[t] = cell_own[t][`OBA_M_M2];
		assign tgt_own_op[t] = cell_own[t][`OBA_M_OP];
		assign tgt_own_if[t] = cell_own[t][`OBA_M_IF];
		// A target with no owner can take a new request in this cycle.
		assign tgt_free[t] = (cell_own[t] == 3'h0);
	end

	// Accept pulses back to the masters.
	assign m2_gnt = |acc_m2;
	assign op_gnt = |acc_op;
	assign if_gnt = |acc_if;

	// ************************************************************
	// Engine activation, configuration and write buffer
	// ************************************************************

	// Next state of the matrix.
	always_comb
	begin
		next_s = s;
		eng_accept = 5'h00;
		// Activations are taken in fixed order, whatever the bus modes.
		unique case (s.eng)
			ENG_IDLE:
			begin
				if (dma_act_req[0])
				begin
					next_s.eng = ENG_DMA0;
					eng_accept = 5'h01;
				end
				else if (dma_act_req[1])
				begin
					next_s.eng = ENG_DMA1;
					eng_accept = 5'h02;
				end
				else if (dma_act_req[2])
				begin
					next_s.eng = ENG_DMA2;
					eng_accept = 5'h04;
				end
				else if (dma_act_req[3])
				begin
					next_s.eng = ENG_DMA3;
					eng_accept = 5'h08;
				end
				else if (dtc_act_req)
				begin
					next_s.eng = ENG_DTC;
					eng_accept = 5'h10;
				end
			end
			ENG_DMA0, ENG_DMA1, ENG_DMA2, ENG_DMA3, ENG_DTC:
			begin
				if (eng_release)
					next_s.eng = ENG_IDLE;
			end
			default:
				next_s.eng = ENG_IDLE;
		endcase
		// Modes load only while no engine runs; reserved bits stay zero.
		if (cfg_load && (s.eng == ENG_IDLE))
		begin
			next_s.prio = {periph6_prio_sel, 2'h0, periph2_prio_sel, periph1_prio_sel,
				rom_bus_prio_sel, ram_bus_prio_sel};
		end
		// A buffered write retires when its peripheral bus reports done.
		if (s.cpu_pend && tgt_done[s.cpu_pend_tgt])
			next_s.cpu_pend = 1'b0;
		if (s.m2_pend && tgt_done[s.m2_pend_tgt])
			next_s.m2_pend = 1'b0;
		// A new accepted peripheral write is recorded after the retire, so it wins.
		if (op_gnt && op_wr && op_tgt_per)
		begin
			next_s.cpu_pend = 1'b1;
			next_s.cpu_pend_tgt = op_tgt;
		end
		if (m2_gnt && m2_wr && m2_tgt_per)
		begin
			next_s.m2_pend = 1'b1;
			next_s.m2_pend_tgt = m2_tgt;
		end
	end

	// Matrix state; everything sits on the one system core clock.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s <= '{eng: ENG_IDLE, prio: `OBA_PRIO_RESET, cpu_pend: 1'b0, cpu_pend_tgt: 3'h0,
				m2_pend: 1'b0, m2_pend_tgt: 3'h0};
		end
		else
			s <= next_s;
	end

	// Status outputs, straight from the state register.
	assign bus_priority_config = s.prio;
	assign eng_owner = {s.eng == ENG_DTC, s.eng == ENG_DMA3, s.eng == ENG_DMA2,
		s.eng == ENG_DMA1, s.eng == ENG_DMA0};

	// ************************************************************
	// Checks
	// ************************************************************

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_ATOMIC_LOCK:
		assert property (atomic_atomic_exchange_instruction_active |-> !m2_gnt)
		else $error("Second main bus accepted during an atomic exchange.");
	AST_DESC_LOCK:
		assert property (dtc_desc_active |-> !op_gnt && !if_gnt)
		else $error("CPU accepted during descriptor access.");
	AST_ENG_FIRST:
		assert property (s.eng == ENG_IDLE && dma_act_req[0] |-> eng_accept == 5'h01
			##1 eng_owner == 5'h01)
		else $error("DMA channel 0 activation not taken first.");
	AST_ENG_DTC_LAST:
		assert property (s.eng == ENG_IDLE && dtc_act_req && dma_act_req != 4'h0
			|=> eng_owner != 5'h10)
		else $error("Descriptor controller beat a DMA channel.");
	AST_M2_NEEDS_ENGINE:
		assert property (m2_gnt |-> $past(eng_owner) != 5'h00 || eng_owner != 5'h00)
		else $error("Second main bus granted with no engine active.");
	AST_ROM_READ_ONLY:
		assert property (op_rom_wr_reject |-> !acc_op[`OBA_TGT_ROM])
		else $error("Direct ROM write accepted.");
	AST_WB_HOLD:
		assert property (s.cpu_pend && op_per && op_tgt != s.cpu_pend_tgt |-> !op_gnt)
		else $error("Access to another peripheral bus passed a buffered write.");
	AST_WB_RECORD:
		assert property (op_gnt && op_wr && op_tgt_per
			|=> s.cpu_pend && s.cpu_pend_tgt == $past(op_tgt))
		else $error("Accepted peripheral write not recorded.");
	COV_CPU_PARALLEL:
		cover property (op_gnt && if_gnt);
	COV_DMA_WITH_CPU:
		cover property (m2_gnt && m2_tgt_per && op_gnt);
	COV_READ_PASSES_WRITE:
		cover property (s.cpu_pend && op_gnt && !op_wr && !op_tgt_per);

	// Matrix-wide checks. The peripheral path of the CPU is one main bus, so
	// a fetch there must wait behind an operand; memory targets need not.
	AST_CPU_BUS_ORDER:
		assert property (op_per && if_req && (if_tgt >= `OBA_TGT_P1) |-> !if_gnt)
		else $error("Fetch passed an operand on the CPU main bus.");
	AST_PARALLEL_MEM:
		assert property (op_live && if_live && op_tgt == `OBA_TGT_RAM
			&& if_tgt == `OBA_TGT_ROM && tgt_free[`OBA_TGT_RAM] && tgt_free[`OBA_TGT_ROM]
			&& !req_m2[`OBA_TGT_RAM] && !req_m2[`OBA_TGT_ROM] |-> op_gnt && if_gnt)
		else $error("Fetch and operand on separate memories did not run together.");
	AST_M2_FREE_TARGET:
		assert property (|(req_m2 & tgt_free & ~req_op & ~req_if) |-> m2_gnt)
		else $error("Lone second main bus request on a free target was not accepted.");
	AST_ENG_SECOND:
		assert property (s.eng == ENG_IDLE && !dma_act_req[0] && dma_act_req[1]
			|-> eng_accept == 5'h02)
		else $error("DMA channel 1 activation not taken second.");
	AST_CFG_LOAD:
		assert property (cfg_load && s.eng == ENG_IDLE
			|=> bus_priority_config[`OBA_PRIO_RAM +: 2] == $past(ram_bus_prio_sel))
		else $error("RAM bus mode not loaded.");
	AST_ROM_REJECT_LEVEL:
		assert property (op_req && op_wr && op_tgt == `OBA_TGT_ROM
			|-> op_rom_wr_reject && !op_gnt)
		else $error("Direct ROM write not refused.");
	AST_WB_RETIRE:
		assert property (s.cpu_pend && tgt_done[s.cpu_pend_tgt]
			&& !(op_gnt && op_wr && op_tgt_per) |=> !s.cpu_pend)
		else $error("Buffered write did not retire on its done pulse.");
	// The exchange lock must still let the CPU itself through.
	COV_EXCHANGE_LOCK:
		cover property (atomic_atomic_exchange_instruction_active && m2_req && op_gnt);

endmodule // oba_matrix

/* design/oba_params.svh */
// Constants of the on-chip bus matrix arbiter: target indices, master slots,
// priority field positions, mode codes and reset values.
// Assumes it is included by the arbiter files by its bare name.
//
// Summary of operation
// - On the CPU main bus, operand access wins over instruction fetch.
// - CPU buses reach RAM and ROM directly; direct ROM path is read only.
// - Fetch and operand to different buses proceed in the same cycle.
// - Memory buses fixed order: second main bus, then operand, then fetch.
// - Toggled mode: the requester just accepted drops to lower priority.
// - RAM and ROM buses each have their own two-bit mode selection.
// - DMA controller beats descriptor controller; DMA, then descriptor, then CPU.
// - Only the engine holding an activation requests; accept DMA 0..3, then descriptor.
// - CPU and another master on different targets run concurrently.
// - During an atomic exchange transfer other masters are refused.
// - During descriptor fetch or write-back other masters are refused.
// - Peripheral bus 1, 2 and 6 serve their own peripheral groups.
// - Peripheral buses fixed order: second main bus before CPU main bus.
// - Peripheral buses 1, 2 and 6 each have their own two-bit mode selection.
// - Peripheral writes are buffered; the next access starts before completion.
// - Next access to another peripheral bus waits for the buffered write.
// - CPU memory read after peripheral write may complete before it.
// - DMA on a peripheral bus runs alongside CPU ROM fetch and RAM operand.
// - Mode code 00 is fixed, 01 toggled; 10 and 11 are prohibited.
// - All buses here run on the one system core clock.
`ifndef OBA_PARAMS_SVH
`define OBA_PARAMS_SVH

// Target buses: RAM, ROM (read path), peripheral bus 1, 2 and 6.
`define OBA_TGT_RAM 3'h0
`define OBA_TGT_ROM 3'h1
`define OBA_TGT_P1 3'h2
`define OBA_TGT_P2 3'h3
`define OBA_TGT_P6 3'h4
`define OBA_NUM_TGT 5

// Master slots in a target arbiter's grant vector.
`define OBA_M_M2 0
`define OBA_M_OP 1
`define OBA_M_IF 2

// Field positions of the priority configuration word.
`define OBA_PRIO_RAM 0
`define OBA_PRIO_ROM 2
`define OBA_PRIO_P1 4
`define OBA_PRIO_P2 6
`define OBA_PRIO_P6 10
`define OBA_PRIO_RESET 12'h000

// Mode codes of a two-bit priority selection.
`define OBA_MODE_FIXED 2'h0
`define OBA_MODE_TOGGLE 2'h1

`endif

/* design/oba_pkg.sv */
// Types of the on-chip bus matrix arbiter.
// Assumes the constants header is compiled alongside.
package oba_pkg;

	// Ownership of the second main bus by the transfer engines.
	typedef enum logic [2:0] {ENG_IDLE, ENG_DMA0, ENG_DMA1, ENG_DMA2, ENG_DMA3, ENG_DTC} oba_eng_t;

	// State of one target bus arbiter.
	typedef struct packed {
		logic busy;
		logic last_m2;
		logic [2:0] own;
	} oba_cell_st_t;

	// State of the matrix.
	typedef struct packed {
		oba_eng_t eng;
		logic [11:0] prio;
		logic cpu_pend;
		logic [2:0] cpu_pend_tgt;
		logic m2_pend;
		logic [2:0] m2_pend_tgt;
	} oba_mx_st_t;

endpackage

/* design/oba_tgt_arb.sv */
// One target bus arbiter: second main bus, CPU operand and CPU fetch slots.
// Assumes requests are held until accepted and done pulses once per transfer.
`timescale 1ns/100ps
`include "oba_params.svh"
module oba_tgt_arb
	import oba_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Mode: high for toggled order.
	input wire logic toggled,
	// Requests.
	input wire logic req_m2,
	input wire logic req_op,
	input wire logic req_if,
	// Completion of the granted transfer.
	input wire logic done,
	// Accept pulse and held ownership, one-hot by master slot.
	output logic [2:0] acc,
	output logic [2:0] own
);

	oba_cell_st_t s;
	oba_cell_st_t next_s;
	logic cpu_req;
	logic m2_wins;

	// ************************************************************
	// Arbitration
	// ************************************************************

	// Pick a winner whenever the bus is free; the owner stays until done.
	always_comb
	begin
		next_s = s;
		acc = 3'h0;
		cpu_req = req_op || req_if;
		// In toggled mode the last accepted side loses the next tie.
		m2_wins = req_m2 && (!toggled || !s.last_m2 || !cpu_req);
		if (s.busy)
		begin
			if (done)
			begin
				next_s.busy = 1'b0;
				next_s.own = 3'h0;
			end
		end
		else if (req_m2 || cpu_req)
		begin
			if (m2_wins)
				acc[`OBA_M_M2] = 1'b1;
			else if (req_op)
				acc[`OBA_M_OP] = 1'b1;
			else
				acc[`OBA_M_IF] = 1'b1;
			next_s.busy = 1'b1;
			next_s.own = acc;
			next_s.last_m2 = acc[`OBA_M_M2];
		end
	end

	// State register; reset leaves the bus free.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			s <= '{busy: 1'b0, last_m2: 1'b0, own: 3'h0};
		else
			s <= next_s;
	end

	assign own = s.own;

	// ************************************************************
	// Checks
	// ************************************************************

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_HOLD_UNTIL_DONE:
		assert property (s.busy && !done |=> $stable(own) && own != 3'h0)
		else $error("Grant changed before its transfer completed.");
	AST_FIXED_M2_FIRST:
		assert property (!s.busy && !toggled && req_m2 |-> acc[`OBA_M_M2] ##1 own == 3'h1)
		else $error("Fixed mode did not give the second main bus priority.");
	AST_OPERAND_FIRST:
		assert property (!s.busy && !req_m2 && req_op && req_if |-> acc == 3'h2)
		else $error("Fetch beat operand access.");
	AST_TOGGLE_DROP:
		assert property (!s.busy && toggled && s.last_m2 && req_m2 && req_op |-> acc[`OBA_M_OP])
		else $error("Toggled mode did not lower the last accepted requester.");
	COV_TOGGLE_SWAP:
		cover property (toggled && acc[`OBA_M_M2] ##[1:20] acc[`OBA_M_OP] && req_m2);

endmodule // oba_tgt_arb

/* sim/oba_tgt_model.sv */
// Behavioural model of the target buses: RAM, ROM and peripheral buses 1, 2, 6.
// Assumes the bench hands it the combined held ownership of each target.
`timescale 1ns/100ps
module oba_tgt_model
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Wait cycles per transfer and held ownership.
	input wire logic [3:0] lat,
	input wire logic [4:0] own,
	// One-cycle completion pulse per target.
	output logic [4:0] done
);
	logic [3:0] cnt [5];

	// A target ends its transfer lat+1 cycles after ownership shows up.
	// A long lat keeps a peripheral write open, so buffered accesses overlap it.
	always_ff @(posedge clock or negedge rst_b)
	begin
		for (int t = 0; t < 5; t++)
		begin
			if (!rst_b || !own[t] || done[t])
			begin
				cnt[t] <= 4'h0;
				done[t] <= 1'b0;
			end
			else
			begin
				cnt[t] <= cnt[t] + 4'h1;
				done[t] <= (cnt[t] == lat);
			end
		end
	end
endmodule // oba_tgt_model

/* sim/test_oba_matrix.sv */
// Self-checking bench of the bus matrix arbiter with a target bus model.
// Assumes inputs change 1 ns after the rising edge; grants are read at 5 ns.
`timescale 1ns/100ps
`include "oba_params.svh"
module test_oba_matrix;
	// ****************************************
	// Signals
	// ****************************************
	logic clock, rst_b, cfg_load, if_req, op_req, op_wr, m2_req, m2_wr, dtc_act_req;
	logic eng_release, atomic_atomic_exchange_instruction_active, dtc_desc_active, if_gnt, op_gnt, m2_gnt;
	logic op_rom_wr_reject;
	logic [1:0] ram_bus_prio_sel, rom_bus_prio_sel, periph1_prio_sel;
	logic [1:0] periph2_prio_sel, periph6_prio_sel;
	logic [2:0] if_tgt, op_tgt, m2_tgt;
	logic [3:0] dma_act_req, lat;
	logic [4:0] tgt_done, tgt_own_m2, tgt_own_op, tgt_own_if, eng_accept, eng_owner;
	logic [11:0] bus_priority_config;
	int err_total, tests_run, k;

	oba_matrix dut (.clock(clock), .rst_b(rst_b), .cfg_load(cfg_load),
		.ram_bus_prio_sel(ram_bus_prio_sel), .rom_bus_prio_sel(rom_bus_prio_sel),
		.periph1_prio_sel(periph1_prio_sel), .periph2_prio_sel(periph2_prio_sel),
		.periph6_prio_sel(periph6_prio_sel), .bus_priority_config(bus_priority_config),
		.if_req(if_req), .if_tgt(if_tgt), .if_gnt(if_gnt), .op_req(op_req),
		.op_tgt(op_tgt), .op_wr(op_wr), .op_gnt(op_gnt), .op_rom_wr_reject(op_rom_wr_reject),
		.m2_req(m2_req), .m2_tgt(m2_tgt), .m2_wr(m2_wr), .m2_gnt(m2_gnt),
		.dma_act_req(dma_act_req), .dtc_act_req(dtc_act_req), .eng_release(eng_release),
		.eng_accept(eng_accept), .eng_owner(eng_owner),
		.atomic_atomic_exchange_instruction_active(atomic_atomic_exchange_instruction_active), .dtc_desc_active(dtc_desc_active),
		.tgt_done(tgt_done), .tgt_own_m2(tgt_own_m2), .tgt_own_op(tgt_own_op),
		.tgt_own_if(tgt_own_if));

	oba_tgt_model model (.clock(clock), .rst_b(rst_b), .lat(lat),
		.own(tgt_own_m2 | tgt_own_op | tgt_own_if), .done(tgt_done));

	// The clock runs at 100 MHz.
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task cyc;
		@(posedge clock);
		#1;
	endtask

	// Grants are combinational, so they are read late in the request cycle.
	task look(input logic [2:0] exp, input string msg);
		#4 chk(12'({m2_gnt, op_gnt, if_gnt}), 12'(exp), msg);
	endtask

	// Holds each request until its grant has been taken at an edge.
	task serve;
		logic gm, go, gi;
		int n;
		for (n = 0; n < 40 && (m2_req || op_req || if_req); n++)
		begin
			gm = m2_gnt;
			go = op_gnt;
			gi = if_gnt;
			cyc();
			if (gm === 1'b1) m2_req = 1'b0;
			if (go === 1'b1) op_req = 1'b0;
			if (gi === 1'b1) if_req = 1'b0;
			if (m2_req || op_req || if_req) #4;
		end
		chk(12'({m2_req, op_req, if_req}), 12'h000, "request never granted");
	endtask

	// Waits until every target bus is free again.
	task quiet;
		int n;
		for (n = 0; n < 50 && (tgt_own_m2 | tgt_own_op | tgt_own_if) !== 5'h00; n++)
			cyc();
		cyc();
	endtask

	task eng(input logic [4:0] mask, input logic [4:0] exp);
		cyc();
		{dtc_act_req, dma_act_req} = mask;
		#4 chk(12'(eng_accept), 12'(exp), "activation accept");
		cyc();
		{dtc_act_req, dma_act_req} = 5'h00;
		#4 chk(12'(eng_owner), 12'(exp), "engine owner");
	endtask

	task rel;
		cyc();
		eng_release = 1'b1;
		cyc();
		eng_release = 1'b0;
		#4 chk(12'(eng_owner), 12'h000, "owner after release");
	endtask

	// A lone second-bus access, then a tie between second bus and operand.
	task race(input logic [2:0] t, input logic m2_first);
		quiet();
		cyc();
		m2_req = 1'b1;
		m2_tgt = t;
		look(3'b100, "lone second bus access");
		serve();
		quiet();
		cyc();
		{m2_req, op_req, op_tgt} = {2'b11, t};
		look(m2_first ? 3'b100 : 3'b010, "tie winner");
		serve();
	endtask

	// ****************************************
	// Tests
	// ****************************************
	// Each access is one transfer to one target and never to register space.
	initial
	begin
		{cfg_load, if_req, op_req, op_wr, m2_req, m2_wr, dtc_act_req, eng_release} = 8'h00;
		{atomic_atomic_exchange_instruction_active, dtc_desc_active, if_tgt, op_tgt, m2_tgt, dma_act_req} = 15'h0;
		{ram_bus_prio_sel, rom_bus_prio_sel, periph1_prio_sel} = 6'h00;
		{periph2_prio_sel, periph6_prio_sel} = 4'h0;
		lat = 4'h2;
		rst_b = 1'b0;
		repeat (3) @(posedge clock);
		#1 rst_b = 1'b1;
		#4 chk(12'({tgt_own_m2, tgt_own_op}), 12'h000, "owners after reset");
		chk(12'({tgt_own_if, eng_owner}), 12'h000, "owners after reset");
		chk(bus_priority_config, 12'h000, "config after reset");
		// Operand beats fetch on one target, and the grant is held.
		cyc();
		{op_req, if_req, op_tgt, if_tgt} = {2'b11, `OBA_TGT_RAM, `OBA_TGT_RAM};
		look(3'b010, "operand before fetch");
		cyc();
		op_req = 1'b0;
		#4 chk(12'({if_gnt, tgt_own_op}), 12'h001, "held grant");
		serve();
		// The direct ROM path never takes a write.
		quiet();
		cyc();
		{op_req, op_wr, op_tgt} = {2'b11, `OBA_TGT_ROM};
		#4 chk(12'({op_rom_wr_reject, op_gnt}), 12'h002, "ROM write");
		cyc();
		{op_req, op_wr} = 2'b00;
		// Fetch from ROM and operand in RAM at once.
		quiet();
		cyc();
		{if_req, op_req, if_tgt, op_tgt} = {2'b11, `OBA_TGT_ROM, `OBA_TGT_RAM};
		look(3'b011, "parallel fetch and operand");
		serve();
		// A slow peripheral write stays buffered while later accesses go on.
		lat = 4'h6;
		quiet();
		cyc();
		{op_req, op_wr, op_tgt} = {2'b11, `OBA_TGT_P2};
		look(3'b010, "buffered write");
		cyc();
		{op_wr, op_tgt} = {1'b0, `OBA_TGT_RAM};
		look(3'b010, "memory read passes write");
		cyc();
		op_tgt = `OBA_TGT_P1;
		#4 chk(12'(op_gnt), 12'h000, "other peripheral bus held");
		cyc();
		// The P2 write and the RAM read are both still open here.
		#4 chk(12'({op_gnt, tgt_own_op}), 12'h009, "write still buffered");
		serve();
		lat = 4'h2;
		// Activations go to the lowest channel, the descriptor engine last.
		for (k = 0; k < 5; k++)
		begin
			eng(5'h1F << k, 5'h01 << k);
			rel();
		end
		// Modes are loaded once, with both engines stopped.
		cyc();
		{ram_bus_prio_sel, rom_bus_prio_sel, periph1_prio_sel} = 6'b01_00_00;
		{periph2_prio_sel, periph6_prio_sel, cfg_load} = 5'b01_01_1;
		cyc();
		cfg_load = 1'b0;
		#4 chk(bus_priority_config, 12'h441, "mode word");
		eng(5'h01, 5'h01);
		// Second-bus peripheral write beside CPU fetch and operand.
		quiet();
		cyc();
		{m2_req, m2_wr, m2_tgt, if_req, if_tgt} = {2'b11, `OBA_TGT_P2, 1'b1, `OBA_TGT_ROM};
		{op_req, op_tgt} = {1'b1, `OBA_TGT_RAM};
		look(3'b111, "three masters in parallel");
		serve();
		m2_wr = 1'b0;
		// Fixed targets keep the second bus first; toggled ones pass the turn on.
		for (k = 0; k < 5; k++)
			race(3'(k), (k == 1 || k == 2));
		// The atomic exchange refuses the second bus until it ends.
		quiet();
		cyc();
		{atomic_atomic_exchange_instruction_active, m2_req, m2_tgt, op_req, op_tgt} = {2'b11, `OBA_TGT_P1, 1'b1, 3'h0};
		look(3'b010, "exchange lock");
		cyc();
		op_req = 1'b0;
		#4 chk(12'(m2_gnt), 12'h000, "exchange lock held");
		cyc();
		atomic_atomic_exchange_instruction_active = 1'b0;
		look(3'b100, "exchange lock ends");
		serve();
		// Descriptor traffic refuses the CPU until it ends.
		quiet();
		cyc();
		{dtc_desc_active, m2_req, m2_tgt, op_req, op_tgt} = {2'b11, 3'h0, 1'b1, `OBA_TGT_P1};
		look(3'b100, "descriptor lock");
		cyc();
		m2_req = 1'b0;
		#4 chk(12'(op_gnt), 12'h000, "descriptor lock held");
		cyc();
		dtc_desc_active = 1'b0;
		look(3'b010, "descriptor lock ends");
		serve();
		// A reset in mid-run drops the loaded modes, the engine and every owner.
		rst_b = 1'b0;
		cyc();
		rst_b = 1'b1;
		#4 chk(bus_priority_config, 12'h000, "config after second reset");
		chk(12'({tgt_own_op, eng_owner}), 12'h000, "owners after second reset");
		rel();
		wrap_up();
	end

	// The tests need a few hundred cycles; this limit is 10000 cycles, far above that.
	initial
	begin
		#100000;
		err_total++;
		$display("[FAIL] %0t run did not finish", $time);
		wrap_up();
	end
endmodule // test_oba_matrix
